// >>> src/gpio_hi_pkg.sv
// Constants, register map and helper functions for the port H and I controller.
// Overview of operation
// - Each port is eight bits, bits 7-0.
// - Every pin is configured independently of neighbours.
// - Port H drive enable bit turns driver on.
// - Port H function bit routes pin to capture.
// - Port H pull-up bit turns pull-up on.
// - Port H pull-up resets with only bit 0.
// - Port H input gate bit opens input path.
// - Port H registers decode at their fixed addresses.
// - Port I pins can serve the timers.
// - Port I resets to plain, all paths off.
// - Port I registers decode at their fixed addresses.
// - Port I data register is eight read-write bits.
// - Port I drive enable bit turns driver on.
// - Port I function bits select timer signals.
// - Port I pull-up and input gate bits work.
package gpio_hi_pkg;

  localparam int          PORT_W        = 8;
  localparam int          BUS_W         = 32;
  localparam int          CAPTURE_W     = 10;
  localparam int          WAVE_W        = 6;

  localparam logic [31:0] PORT_H_BASE   = 32'h4000_01C0;
  localparam logic [31:0] PORT_I_BASE   = 32'h4000_0200;

  localparam logic [31:0] OFS_DATA      = 32'h0000_0000;
  localparam logic [31:0] OFS_DRIVE     = 32'h0000_0004;
  localparam logic [31:0] OFS_FUNC      = 32'h0000_0008;
  localparam logic [31:0] OFS_RESERVED  = 32'h0000_0010;
  localparam logic [31:0] OFS_PULLUP    = 32'h0000_002C;
  localparam logic [31:0] OFS_INPUT     = 32'h0000_0038;

  localparam logic [7:0]  PORT_RST      = 8'h00;
  localparam logic [7:0]  H_PULLUP_RST  = 8'h01;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

  // Port I pins 0 to 5 carry timer waves out, pins 6 and 7 feed timer 4 capture.
  localparam logic [7:0]  I_ALT_IS_OUT  = 8'h3F;
  localparam logic [7:0]  H_ALT_IS_OUT  = 8'h00;

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_H_DATA,
    SEL_H_DRIVE,
    SEL_H_FUNC,
    SEL_H_PULLUP,
    SEL_H_INPUT,
    SEL_I_DATA,
    SEL_I_DRIVE,
    SEL_I_FUNC,
    SEL_I_PULLUP,
    SEL_I_INPUT
  } reg_sel_t;

  function automatic logic addr_hit(input logic [31:0] adr,
                                    input logic [31:0] base,
                                    input logic [31:0] ofs);
    logic [31:0] target;
    target = base + ofs;
    return adr == target;
  endfunction : addr_hit

  // Only byte lane 0 holds live bits; the other lanes are discarded.
  function automatic logic [7:0] lane_write(input logic [7:0]  old_val,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
    return sel[0] ? dat[7:0] : old_val;
  endfunction : lane_write

endpackage : gpio_hi_pkg

// >>> src/gpio_pin_cell.sv
// One pin of a port: driver, pull-up, input gate and alternate function steering.
module gpio_pin_cell
  import gpio_hi_pkg::*;
(
  // Configuration bits for this pin
  input  wire logic i_data,
  input  wire logic i_drive_en,
  input  wire logic i_input_en,
  input  wire logic i_pullup_en,
  input  wire logic i_alt_sel,
  // Alternate function
  input  wire logic i_alt_is_out,
  input  wire logic i_alt_drive,
  output logic      o_alt_in,
  // Pad side
  input  wire logic i_pin,
  output logic      o_pin,
  output logic      o_pin_oe,
  output logic      o_pullup,
  // Value seen by a data register read
  output logic      o_pin_seen
);

  logic gated_in;

  // The input gate keeps a floating pad from toggling logic while it is closed.
  assign gated_in   = i_pin & i_input_en;
  assign o_pin_oe   = i_drive_en;
  assign o_pin      = i_drive_en & ((i_alt_sel & i_alt_is_out) ? i_alt_drive : i_data);
  assign o_pullup   = i_pullup_en;
  assign o_alt_in   = i_alt_sel & ~i_alt_is_out & gated_in;
  assign o_pin_seen = i_drive_en ? i_data : gated_in;

endmodule : gpio_pin_cell

// >>> src/gpio_port_h_i_control.sv
// Top of the port H and I controller with its Wishbone register slave.
//
// Our own choice: the Wishbone register port.
module gpio_port_h_i_control
  import gpio_hi_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_b,
  // Wishbone classic slave
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic [31:0]          i_wb_adr,
  input  wire logic [3:0]           i_wb_sel,
  input  wire logic [BUS_W-1:0]     i_wb_dat,
  output logic      [BUS_W-1:0]     o_wb_dat,
  output logic                      o_wb_ack,
  // Port H pads
  input  wire logic [PORT_W-1:0]    i_hpin,
  output logic      [PORT_W-1:0]    o_hpin,
  output logic      [PORT_W-1:0]    o_hpin_oe,
  output logic      [PORT_W-1:0]    o_hpin_pullup,
  // Port I pads
  input  wire logic [PORT_W-1:0]    i_ipin,
  output logic      [PORT_W-1:0]    o_ipin,
  output logic      [PORT_W-1:0]    o_ipin_oe,
  output logic      [PORT_W-1:0]    o_ipin_pullup,
  // Timer connections
  input  wire logic [WAVE_W-1:0]    i_timer_wave_out,
  output logic      [CAPTURE_W-1:0] o_timer_capture_in
);

  logic [7:0] port_h_pin_data_reg;
  logic [7:0] port_h_output_enable_reg;
  logic [7:0] port_h_function_select_reg;
  logic [7:0] port_h_pullup_enable_reg;
  logic [7:0] port_h_input_enable_reg;
  logic [7:0] port_i_pin_data_reg;
  logic [7:0] port_i_output_enable_reg;
  logic [7:0] port_i_function_select_reg;
  logic [7:0] port_i_pullup_enable_reg;
  logic [7:0] port_i_input_enable_reg;

  logic             ack_reg;
  logic [BUS_W-1:0] rdata_reg;
  logic [BUS_W-1:0] rdata_next;
  reg_sel_t         sel_code;
  logic             req;
  logic             wr_go;
  logic             rd_go;
  logic [7:0]       hport_seen;
  logic [7:0]       iport_seen;
  logic [7:0]       hport_capture;
  logic [7:0]       iport_capture;
  logic [7:0]       iport_wave;

  // Address decode; reserved and unmapped words fall to SEL_NONE.
  always_comb begin
    sel_code = SEL_NONE;
    if (addr_hit(i_wb_adr, PORT_H_BASE, OFS_DATA)) begin
      sel_code = SEL_H_DATA;
    end else if (addr_hit(i_wb_adr, PORT_H_BASE, OFS_DRIVE)) begin
      sel_code = SEL_H_DRIVE;
    end else if (addr_hit(i_wb_adr, PORT_H_BASE, OFS_FUNC)) begin
      sel_code = SEL_H_FUNC;
    end else if (addr_hit(i_wb_adr, PORT_H_BASE, OFS_PULLUP)) begin
      sel_code = SEL_H_PULLUP;
    end else if (addr_hit(i_wb_adr, PORT_H_BASE, OFS_INPUT)) begin
      sel_code = SEL_H_INPUT;
    end else if (addr_hit(i_wb_adr, PORT_I_BASE, OFS_DATA)) begin
      sel_code = SEL_I_DATA;
    end else if (addr_hit(i_wb_adr, PORT_I_BASE, OFS_DRIVE)) begin
      sel_code = SEL_I_DRIVE;
    end else if (addr_hit(i_wb_adr, PORT_I_BASE, OFS_FUNC)) begin
      sel_code = SEL_I_FUNC;
    end else if (addr_hit(i_wb_adr, PORT_I_BASE, OFS_PULLUP)) begin
      sel_code = SEL_I_PULLUP;
    end else if (addr_hit(i_wb_adr, PORT_I_BASE, OFS_INPUT)) begin
      sel_code = SEL_I_INPUT;
    end
  end

  assign req   = i_wb_cyc & i_wb_stb;
  // Writes land on the edge where the master sees ack, so a held request commits once.
  assign wr_go = req & i_wb_we & ack_reg;
  assign rd_go = req & ~i_wb_we & ~ack_reg;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_comb begin
    rdata_next = READ_ZERO;
    case (sel_code)
      SEL_H_DATA:   rdata_next[7:0] = hport_seen;
      SEL_H_DRIVE:  rdata_next[7:0] = port_h_output_enable_reg;
      SEL_H_FUNC:   rdata_next[7:0] = port_h_function_select_reg;
      SEL_H_PULLUP: rdata_next[7:0] = port_h_pullup_enable_reg;
      SEL_H_INPUT:  rdata_next[7:0] = port_h_input_enable_reg;
      SEL_I_DATA:   rdata_next[7:0] = iport_seen;
      SEL_I_DRIVE:  rdata_next[7:0] = port_i_output_enable_reg;
      SEL_I_FUNC:   rdata_next[7:0] = port_i_function_select_reg;
      SEL_I_PULLUP: rdata_next[7:0] = port_i_pullup_enable_reg;
      SEL_I_INPUT:  rdata_next[7:0] = port_i_input_enable_reg;
      // Reserved words answer with zero so a stray access cannot hang the bus.
      SEL_NONE:     rdata_next = READ_ZERO;
      default:      rdata_next = READ_ZERO;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rdata_reg <= READ_ZERO;
    end else if (rd_go) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdata_reg;

  // Each register keeps only its low byte; the bus bits above are dropped.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_h_pin_data_reg <= PORT_RST;
    end else if (wr_go && sel_code == SEL_H_DATA) begin
      port_h_pin_data_reg <= lane_write(port_h_pin_data_reg, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_h_output_enable_reg <= PORT_RST;
    end else if (wr_go && sel_code == SEL_H_DRIVE) begin
      port_h_output_enable_reg <= lane_write(port_h_output_enable_reg, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_h_function_select_reg <= PORT_RST;
    end else if (wr_go && sel_code == SEL_H_FUNC) begin
      port_h_function_select_reg <= lane_write(port_h_function_select_reg, i_wb_dat,
                                               i_wb_sel);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_h_pullup_enable_reg <= H_PULLUP_RST;
    end else if (wr_go && sel_code == SEL_H_PULLUP) begin
      port_h_pullup_enable_reg <= lane_write(port_h_pullup_enable_reg, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_h_input_enable_reg <= PORT_RST;
    end else if (wr_go && sel_code == SEL_H_INPUT) begin
      port_h_input_enable_reg <= lane_write(port_h_input_enable_reg, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_i_pin_data_reg <= PORT_RST;
    end else if (wr_go && sel_code == SEL_I_DATA) begin
      port_i_pin_data_reg <= lane_write(port_i_pin_data_reg, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_i_output_enable_reg <= PORT_RST;
    end else if (wr_go && sel_code == SEL_I_DRIVE) begin
      port_i_output_enable_reg <= lane_write(port_i_output_enable_reg, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_i_function_select_reg <= PORT_RST;
    end else if (wr_go && sel_code == SEL_I_FUNC) begin
      port_i_function_select_reg <= lane_write(port_i_function_select_reg, i_wb_dat,
                                               i_wb_sel);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_i_pullup_enable_reg <= PORT_RST;
    end else if (wr_go && sel_code == SEL_I_PULLUP) begin
      port_i_pullup_enable_reg <= lane_write(port_i_pullup_enable_reg, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port_i_input_enable_reg <= PORT_RST;
    end else if (wr_go && sel_code == SEL_I_INPUT) begin
      port_i_input_enable_reg <= lane_write(port_i_input_enable_reg, i_wb_dat, i_wb_sel);
    end
  end

  // Pins 6 and 7 of port I are capture inputs, so they never take a timer wave.
  assign iport_wave = {2'b00, i_timer_wave_out};

  // One cell per pin keeps every pin's settings apart from its neighbours.
  for (genvar k = 0; k < PORT_W; k++) begin : g_pin
    gpio_pin_cell u_hcell (
      .i_data       (port_h_pin_data_reg[k]),
      .i_drive_en   (port_h_output_enable_reg[k]),
      .i_input_en   (port_h_input_enable_reg[k]),
      .i_pullup_en  (port_h_pullup_enable_reg[k]),
      .i_alt_sel    (port_h_function_select_reg[k]),
      .i_alt_is_out (H_ALT_IS_OUT[k]),
      .i_alt_drive  (1'b0),
      .o_alt_in     (hport_capture[k]),
      .i_pin        (i_hpin[k]),
      .o_pin        (o_hpin[k]),
      .o_pin_oe     (o_hpin_oe[k]),
      .o_pullup     (o_hpin_pullup[k]),
      .o_pin_seen   (hport_seen[k])
    );
    gpio_pin_cell u_icell (
      .i_data       (port_i_pin_data_reg[k]),
      .i_drive_en   (port_i_output_enable_reg[k]),
      .i_input_en   (port_i_input_enable_reg[k]),
      .i_pullup_en  (port_i_pullup_enable_reg[k]),
      .i_alt_sel    (port_i_function_select_reg[k]),
      .i_alt_is_out (I_ALT_IS_OUT[k]),
      .i_alt_drive  (iport_wave[k]),
      .o_alt_in     (iport_capture[k]),
      .i_pin        (i_ipin[k]),
      .o_pin        (o_ipin[k]),
      .o_pin_oe     (o_ipin_oe[k]),
      .o_pullup     (o_ipin_pullup[k]),
      .o_pin_seen   (iport_seen[k])
    );
  end

  // Capture bus: timer t input n sits at index 2t+n; timer 4 comes from port I.
  assign o_timer_capture_in = {iport_capture[7:6], hport_capture};

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_ack_single_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack stayed high for more than one cycle");
  a_ack_next_cycle: assert property ((req && !o_wb_ack) |=> o_wb_ack)
    else $error("request not answered in the next cycle");
  a_upper_bits_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_reserved_reads_zero: assert property ((rd_go && sel_code == SEL_NONE) |=>
                                          (o_wb_ack && o_wb_dat == READ_ZERO))
    else $error("reserved or unmapped read not zero");
  a_h_pullup_reset: assert property ($rose(i_rst_b) |-> o_hpin_pullup == H_PULLUP_RST)
    else $error("port H pull-up reset value wrong");
  a_i_reset_off: assert property ($rose(i_rst_b) |->
                                  (o_ipin_oe == 8'h00 && o_ipin_pullup == 8'h00 &&
                                   o_timer_capture_in[9:8] == 2'b00))
    else $error("port I not idle after reset");
  a_h_drive_write: assert property ((wr_go && sel_code == SEL_H_DRIVE && i_wb_sel[0])
                                    |=> o_hpin_oe == $past(i_wb_dat[7:0]))
    else $error("port H drive enable write not applied");
  a_i_drive_write: assert property ((wr_go && sel_code == SEL_I_DRIVE && i_wb_sel[0])
                                    |=> o_ipin_oe == $past(i_wb_dat[7:0]))
    else $error("port I drive enable write not applied");
  a_h_pullup_write: assert property ((wr_go && sel_code == SEL_H_PULLUP && i_wb_sel[0])
                                     |=> o_hpin_pullup == $past(i_wb_dat[7:0]))
    else $error("port H pull-up write not applied");
  a_i_data_write: assert property ((wr_go && sel_code == SEL_I_DATA && i_wb_sel[0])
                                   |=> port_i_pin_data_reg == $past(i_wb_dat[7:0]))
    else $error("port I data write not applied");

  // Data reads return the latch for driven bits and the gated pad for the rest.
  a_i_data_read: assert property ((rd_go && sel_code == SEL_I_DATA) |=>
                                  o_wb_dat[7:0] == (($past(port_i_pin_data_reg) &
                                  $past(o_ipin_oe)) | ($past(i_ipin) &
                                  $past(port_i_input_enable_reg) & ~$past(o_ipin_oe))))
    else $error("port I data readback wrong");
  a_h_data_read: assert property ((rd_go && sel_code == SEL_H_DATA) |=>
                                  o_wb_dat[7:0] == (($past(port_h_pin_data_reg) &
                                  $past(o_hpin_oe)) | ($past(i_hpin) &
                                  $past(port_h_input_enable_reg) & ~$past(o_hpin_oe))))
    else $error("port H data readback wrong");
  a_h_capture_route: assert property (o_timer_capture_in[7:0] ==
                                      (i_hpin & port_h_function_select_reg &
                                       port_h_input_enable_reg))
    else $error("port H capture routing wrong");
  a_i_wave_route: assert property ((port_i_function_select_reg[0] &&
                                    o_ipin_oe[0]) |-> o_ipin[0] == i_timer_wave_out[0])
    else $error("timer 0 wave not on port I pin 0");
  a_i_capture_gate: assert property ((!port_i_input_enable_reg[6]) |->
                                     !o_timer_capture_in[8])
    else $error("port I capture passed with input gate closed");
  a_off_not_driven: assert property (((o_hpin & ~o_hpin_oe) == 8'h00) &&
                                     ((o_ipin & ~o_ipin_oe) == 8'h00))
    else $error("pin value present while driver disabled");

  // Configuration writes land on the ack edge and show one cycle later.
  a_h_data_write: assert property ((wr_go && i_wb_sel[0] &&
                                    sel_code == SEL_H_DATA) |=>
                                   port_h_pin_data_reg == $past(i_wb_dat[7:0]))
    else $error("port H data write not applied");
  a_h_func_write: assert property ((wr_go && i_wb_sel[0] &&
                                    sel_code == SEL_H_FUNC) |=>
                                   port_h_function_select_reg == $past(i_wb_dat[7:0]))
    else $error("port H function write not applied");
  a_h_input_write: assert property ((wr_go && i_wb_sel[0] &&
                                     sel_code == SEL_H_INPUT) |=>
                                    port_h_input_enable_reg == $past(i_wb_dat[7:0]))
    else $error("port H input gate write not applied");
  a_i_func_write: assert property ((wr_go && i_wb_sel[0] &&
                                    sel_code == SEL_I_FUNC) |=>
                                   port_i_function_select_reg == $past(i_wb_dat[7:0]))
    else $error("port I function write not applied");
  a_i_pullup_write: assert property ((wr_go && i_wb_sel[0] &&
                                      sel_code == SEL_I_PULLUP) |=>
                                     o_ipin_pullup == $past(i_wb_dat[7:0]))
    else $error("port I pull-up write not applied");
  a_i_input_write: assert property ((wr_go && i_wb_sel[0] &&
                                     sel_code == SEL_I_INPUT) |=>
                                    port_i_input_enable_reg == $past(i_wb_dat[7:0]))
    else $error("port I input gate write not applied");
  a_lane_off_kept: assert property ((wr_go && !i_wb_sel[0]) |=>
                                    ($stable({o_hpin_oe, o_ipin_oe}) &&
                                     $stable({o_hpin_pullup, o_ipin_pullup})))
    else $error("write with lane 0 off changed a setting");
  a_rdata_hold: assert property (!rd_go |=> $stable(o_wb_dat))
    else $error("read data changed without a read");
  a_bus_reset_idle: assert property ($rose(i_rst_b) |-> (!o_wb_ack && o_wb_dat == READ_ZERO))
    else $error("bus outputs not idle after reset");
  a_i_pin67_plain: assert property (o_ipin[7:6] == (port_i_pin_data_reg[7:6] &
                                    o_ipin_oe[7:6]))
    else $error("port I capture pin drove a timer wave");
  a_h_pins_plain: assert property (o_hpin == (port_h_pin_data_reg & o_hpin_oe))
    else $error("port H pin drove a non-data value");

  c_h_drive_write: cover property (wr_go && sel_code == SEL_H_DRIVE);
  c_i_data_read: cover property (rd_go && sel_code == SEL_I_DATA ##1 o_wb_ack);
  c_reserved_access: cover property (req && sel_code == SEL_NONE ##1 o_wb_ack);
  c_timer_capture: cover property (|o_timer_capture_in);
  c_i_wave_out: cover property (port_i_function_select_reg[0] && o_ipin_oe[0]);

endmodule : gpio_port_h_i_control

// >>> tb/gpio_pad_model.sv
// Board side of one eight-pin port: external drivers, pull-ups and floating pads.
module gpio_pad_model (
  // Clock
  input  wire logic       i_ref_clk,
  // Device pad outputs
  input  wire logic [7:0] i_pad_out,
  input  wire logic [7:0] i_pad_oe,
  input  wire logic [7:0] i_pad_pullup,
  // External drivers on the board
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  // Level seen at the pads
  output logic      [7:0] o_level
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] float_reg;

  // A floating pad must never look settled, so its level toggles every cycle.
  initial float_reg = 8'h55;
  always @(posedge i_ref_clk) begin
    float_reg <= ~float_reg;
  end

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if (i_pad_oe[k]) begin
        o_level[k] = i_pad_out[k];
      end else if (i_ext_en[k]) begin
        o_level[k] = i_ext_val[k];
      end else if (i_pad_pullup[k]) begin
        o_level[k] = 1'b1;
      end else begin
        o_level[k] = float_reg[k];
      end
    end
  end
endmodule : gpio_pad_model

// >>> tb/gpio_port_h_i_control_test.sv
// Self-checking bench for the port H and I controller.
module gpio_port_h_i_control_test;
  import gpio_hi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_ref_clk, i_rst_b, wb_cyc, wb_stb, wb_we, o_wb_ack;
  logic [31:0] wb_adr, wb_wdat, o_wb_dat;
  logic [3:0] wb_sel;
  logic [7:0] hpin, ipin, o_hpin, o_hpin_oe, o_hpin_pu, o_ipin, o_ipin_oe, o_ipin_pu;
  logic [7:0] ext_h_en, ext_h_val, ext_i_en, ext_i_val;
  logic [WAVE_W-1:0] wave;
  logic [CAPTURE_W-1:0] capture;
  int error_cnt, total_checks, cycle_cnt;
  logic [31:0] ofs_tab [5];
  logic [31:0] scratch;

  gpio_port_h_i_control u_dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_hpin(hpin), .o_hpin(o_hpin),
    .o_hpin_oe(o_hpin_oe), .o_hpin_pullup(o_hpin_pu), .i_ipin(ipin), .o_ipin(o_ipin),
    .o_ipin_oe(o_ipin_oe), .o_ipin_pullup(o_ipin_pu), .i_timer_wave_out(wave),
    .o_timer_capture_in(capture));
  gpio_pad_model u_hpads (.i_ref_clk(i_ref_clk), .i_pad_out(o_hpin), .i_pad_oe(o_hpin_oe),
    .i_pad_pullup(o_hpin_pu), .i_ext_en(ext_h_en), .i_ext_val(ext_h_val), .o_level(hpin));
  gpio_pad_model u_ipads (.i_ref_clk(i_ref_clk), .i_pad_out(o_ipin), .i_pad_oe(o_ipin_oe),
    .i_pad_pullup(o_ipin_pu), .i_ext_en(ext_i_en), .i_ext_val(ext_i_val), .o_level(ipin));

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // Ceiling is far above the few hundred cycles the sequence needs.
  always @(posedge i_ref_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      error_cnt++;
      $display("timeout after %0d cycles", cycle_cnt);
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // No latency is assumed: the request stays up until ack is seen at an edge.
  task automatic wb_access(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                           input logic [3:0] sel, output logic [31:0] rdat);
    @(posedge i_ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    wb_sel <= sel;
    do @(posedge i_ref_clk); while (o_wb_ack !== 1'b1);
    rdat = o_wb_dat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_access

  task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb_access(1'b1, adr, dat, 4'h1, d);
  endtask : wr

  task automatic rd_chk(input logic [31:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb_access(1'b0, adr, 32'h0000_0000, 4'hF, d);
    check(d, exp);
  endtask : rd_chk

  // Lets the commit edge land before pad outputs are looked at.
  task automatic settle();
    @(negedge i_ref_clk);
  endtask : settle

  task automatic check_reset_state();
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 5; r++) begin
        rd_chk((p == 1 ? PORT_I_BASE : PORT_H_BASE) + ofs_tab[r],
               (p == 0 && r == 3) ? 32'h0000_0001 : 32'h0000_0000);
      end
    end
    check({24'h00_0000, o_hpin_pu}, 32'h0000_0001);
    check({o_hpin_oe, o_ipin_oe, o_ipin_pu, 8'h00}, 32'h0000_0000);
  endtask : check_reset_state

  initial begin
    ofs_tab = '{OFS_DATA, OFS_DRIVE, OFS_FUNC, OFS_PULLUP, OFS_INPUT};
    {wb_cyc, wb_stb, wb_we, i_rst_b} = 4'h0;
    {wb_adr, wb_wdat, wb_sel} = 68'h0;
    {ext_h_en, ext_h_val, ext_i_en, ext_i_val} = 32'h0000_0000;
    wave = 6'h00;
    error_cnt = 0;
    total_checks = 0;
    cycle_cnt = 0;
    repeat (20) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    check_reset_state();
    // Config registers: upper bits dropped, disabled lane dropped, exact decode.
    for (int p = 0; p < 2; p++) begin
      for (int r = 1; r < 5; r++) begin
        wr((p == 1 ? PORT_I_BASE : PORT_H_BASE) + ofs_tab[r], 32'hDEAD_BE5A);
        rd_chk((p == 1 ? PORT_I_BASE : PORT_H_BASE) + ofs_tab[r], 32'h0000_005A);
        wb_access(1'b1, (p == 1 ? PORT_I_BASE : PORT_H_BASE) + ofs_tab[r], 32'h0000_00FF,
                  4'h0, scratch);
        rd_chk((p == 1 ? PORT_I_BASE : PORT_H_BASE) + ofs_tab[r], 32'h0000_005A);
        wr((p == 1 ? PORT_I_BASE : PORT_H_BASE) + ofs_tab[r], 32'h0000_0000);
      end
      // Unmapped word below the reserved area; software never touches the reserved area.
      wr((p == 1 ? PORT_I_BASE : PORT_H_BASE) + 32'h0000_000C, 32'h0000_00FF);
      rd_chk((p == 1 ? PORT_I_BASE : PORT_H_BASE) + 32'h0000_000C, 32'h0000_0000);
      rd_chk((p == 1 ? PORT_I_BASE : PORT_H_BASE) + OFS_DATA, 32'h0000_0000);
    end
    // Per-pin drivers: undriven pins stay quiet whatever the data holds.
    wr(PORT_I_BASE + OFS_DATA, 32'h0000_005A);
    wr(PORT_I_BASE + OFS_DRIVE, 32'h0000_000F);
    settle();
    check({24'h00_0000, o_ipin_oe}, 32'h0000_000F);
    check({24'h00_0000, o_ipin}, 32'h0000_000A);
    rd_chk(PORT_I_BASE + OFS_DATA, 32'h0000_000A);
    @(posedge i_ref_clk);
    ext_i_en <= 8'hF0;
    ext_i_val <= 8'hC0;
    wr(PORT_I_BASE + OFS_INPUT, 32'h0000_00F0);
    rd_chk(PORT_I_BASE + OFS_DATA, 32'h0000_00CA);
    wr(PORT_H_BASE + OFS_DATA, 32'h0000_0033);
    wr(PORT_H_BASE + OFS_DRIVE, 32'h0000_00F0);
    wr(PORT_H_BASE + OFS_PULLUP, 32'h0000_0082);
    wr(PORT_I_BASE + OFS_PULLUP, 32'h0000_0041);
    settle();
    check({16'h0000, o_hpin_oe, o_hpin}, 32'h0000_F030);
    check({16'h0000, o_hpin_pu, o_ipin_pu}, 32'h0000_8241);
    // Port H capture routing, one pin at a time.
    wr(PORT_H_BASE + OFS_DRIVE, 32'h0000_0000);
    wr(PORT_H_BASE + OFS_FUNC, 32'h0000_00FF);
    wr(PORT_H_BASE + OFS_INPUT, 32'h0000_00FF);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_ref_clk);
      ext_h_en <= 8'hFF;
      ext_h_val <= 8'h01 << k;
      settle();
      check(32'(capture), 32'h0000_0001 << k);
    end
    wr(PORT_H_BASE + OFS_FUNC, 32'h0000_000F);
    @(posedge i_ref_clk);
    ext_h_val <= 8'hFF;
    settle();
    check(32'(capture), 32'h0000_000F);
    rd_chk(PORT_H_BASE + OFS_DATA, 32'h0000_00FF);
    // Port I timer waves out on pins 0 to 5, capture in on pins 6 and 7.
    wr(PORT_I_BASE + OFS_DATA, 32'h0000_0015);
    wr(PORT_I_BASE + OFS_DRIVE, 32'h0000_003F);
    wr(PORT_I_BASE + OFS_FUNC, 32'h0000_00FF);
    wr(PORT_I_BASE + OFS_INPUT, 32'h0000_00C0);
    @(posedge i_ref_clk);
    ext_i_en <= 8'hC0;
    ext_i_val <= 8'h80;
    wave <= 6'h2D;
    settle();
    check({24'h00_0000, o_ipin}, 32'h0000_002D);
    check(32'(capture[9:8]), 32'h0000_0002);
    wr(PORT_I_BASE + OFS_FUNC, 32'h0000_0000);
    settle();
    check({24'h00_0000, o_ipin}, 32'h0000_0015);
    check(32'(capture[9:8]), 32'h0000_0000);
    // Second reset in mid-run restores every default.
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    ext_h_en <= 8'h00;
    ext_i_en <= 8'h00;
    settle();
    check_reset_state();
    give_verdict();
  end
endmodule : gpio_port_h_i_control_test
